// file: rtl/nand_host_pkg.sv
package nand_host_pkg;

  localparam int CLK_NS      = 40;
  localparam int T_WP_NS     = 25;
  localparam int T_WH_NS     = 15;
  localparam int T_REA_NS    = 25;
  localparam int T_WB_NS     = 100;
  localparam int SYNC_STAGES = 2;

  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam logic [3:0] WE_LOW_CYC  = 4'(cyc_up(T_WP_NS));
  localparam logic [3:0] WE_HIGH_CYC = 4'(cyc_up(T_WH_NS));
  // Strobe stays low long enough for the data to pass the synchroniser
  localparam logic [3:0] RD_LOW_CYC  = 4'(cyc_up(T_REA_NS) + SYNC_STAGES + 1);
  localparam logic [3:0] WB_CYC      = 4'(cyc_up(T_WB_NS));

  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int COL_W   = 12;
  localparam int PAGE_W  = 6;
  localparam int BLK_W   = 11;

  localparam logic [2:0] ADDR_LAST = 3'h4;

  localparam int X8_COL_TOP   = 11;
  localparam int X16_COL_TOP  = 10;

  typedef enum logic [2:0] {
    KIND_CMD   = 3'b000,
    KIND_ADDR  = 3'b001,
    KIND_WRITE = 3'b010,
    KIND_READ  = 3'b011,
    KIND_WAIT  = 3'b100
  } req_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_SETUP    = 3'b001,
    ST_STROBE   = 3'b010,
    ST_HOLD     = 3'b011,
    ST_WAIT_WB  = 3'b100,
    ST_WAIT_RDY = 3'b101
  } state_t;

endpackage : nand_host_pkg

// file: rtl/pair_buffer.sv
`timescale 1ns/1ps
module pair_buffer
(
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  input  wire logic                             in_valid,
  output logic                                  in_ready,
  input  wire logic [nand_host_pkg::DATA_W-1:0] in_data,
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic [nand_host_pkg::DATA_W-1:0]      out_data
);

  logic [nand_host_pkg::DATA_W-1:0] mem [2];
  logic                             wr_ptr_reg;
  logic                             rd_ptr_reg;
  logic [1:0]                       count_reg;
  logic                             push;
  logic                             pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : pair_buffer

// file: rtl/nand_host_port.sv
// Function
// - Command, then addresses, then data cycles
// - Five address cycles in documented layout
// - Byte-wide: column 11 clears columns 10..6
// - Word-wide: column 10 clears columns 9..5
`timescale 1ns/1ps
module nand_host_port
(
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic                                req_valid,
  output logic                                     req_ready,
  input  wire nand_host_pkg::req_kind_t            req_kind,
  input  wire logic [nand_host_pkg::DATA_W-1:0]    req_data,
  input  wire logic [nand_host_pkg::COL_W-1:0]     req_col,
  input  wire logic [nand_host_pkg::PAGE_W-1:0]    req_page,
  input  wire logic [nand_host_pkg::BLK_W-1:0]     req_block,
  input  wire logic                                bus_x16,
  input  wire logic                                prog_enable,
  input  wire logic                                lock_enable,
  output logic                                     rd_valid,
  input  wire logic                                rd_ready,
  output logic [nand_host_pkg::DATA_W-1:0]         rd_data,
  output logic                                     busy,
  output logic                                     ce_n,
  output logic                                     cle,
  output logic                                     ale,
  output logic                                     we_n,
  output logic                                     read_strobe_n,
  output logic                                     wp_n,
  output logic                                     block_guard,
  output logic [nand_host_pkg::DATA_W-1:0]         io_out,
  output logic                                     io_oe,
  input  wire logic [nand_host_pkg::DATA_W-1:0]    io_in,
  input  wire logic                                ready_busy_n
);

  nand_host_pkg::state_t            state_reg;
  nand_host_pkg::req_kind_t         kind_reg;
  logic [nand_host_pkg::DATA_W-1:0] data_reg;
  logic [nand_host_pkg::COL_W-1:0]  col_reg;
  logic [nand_host_pkg::PAGE_W-1:0] page_reg;
  logic [nand_host_pkg::BLK_W-1:0]  blk_reg;
  logic [2:0]                       idx_reg;
  logic [3:0]                       cnt_reg;
  logic                             x16_reg;
  logic                             rb_s1;
  logic                             rb_s2;
  logic [nand_host_pkg::DATA_W-1:0] io_s1;
  logic [nand_host_pkg::DATA_W-1:0] io_s2;
  logic                             buf_in_ready;
  logic                             push;
  logic                             active;
  logic                             accept;

  // Column bits that the device requires clear once the top column bit is set
  function automatic logic [nand_host_pkg::COL_W-1:0] col_fix(
    input logic [nand_host_pkg::COL_W-1:0] col,
    input logic                            x16);
    logic [nand_host_pkg::COL_W-1:0] c;
    c = col;
    if (x16)
    begin
      c[nand_host_pkg::X8_COL_TOP] = 1'b0;
      if (c[nand_host_pkg::X16_COL_TOP])
      begin
        c[9:5] = 5'h00;
      end
    end
    else if (c[nand_host_pkg::X8_COL_TOP])
    begin
      c[10:6] = 5'h00;
    end
    return c;
  endfunction : col_fix

  function automatic logic [nand_host_pkg::BYTE_W-1:0] addr_cycle(
    input logic [2:0]                        idx,
    input logic [nand_host_pkg::COL_W-1:0]   col,
    input logic [nand_host_pkg::PAGE_W-1:0]  page,
    input logic [nand_host_pkg::BLK_W-1:0]   blk,
    input logic                              x16);
    logic [nand_host_pkg::BYTE_W-1:0] b;
    b = 8'h00;
    unique case (idx)
      3'h0: b = col[7:0];
      3'h1: b = x16 ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
      3'h2: b = {blk[1:0], page};  // blk[0] is block bit six, the plane select
      3'h3: b = blk[9:2];
      3'h4: b = {7'h00, blk[10]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : addr_cycle

  assign active    = (state_reg == nand_host_pkg::ST_SETUP) ||
                     (state_reg == nand_host_pkg::ST_STROBE) ||
                     (state_reg == nand_host_pkg::ST_HOLD);
  // A read is only started when the buffer can take its word
  assign req_ready = (state_reg == nand_host_pkg::ST_IDLE) &&
                     ((req_kind != nand_host_pkg::KIND_READ) || buf_in_ready);
  assign accept    = req_valid && req_ready;
  assign push      = (state_reg == nand_host_pkg::ST_STROBE) && (cnt_reg == 4'h1) &&
                     (kind_reg == nand_host_pkg::KIND_READ);
  assign busy      = (state_reg != nand_host_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      io_s1 <= 16'h0000;
      io_s2 <= 16'h0000;
    end
    else
    begin
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= nand_host_pkg::ST_IDLE;
      kind_reg  <= nand_host_pkg::KIND_CMD;
      data_reg  <= 16'h0000;
      col_reg   <= 12'h000;
      page_reg  <= 6'h00;
      blk_reg   <= 11'h000;
      idx_reg   <= 3'h0;
      cnt_reg   <= 4'h0;
      x16_reg   <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        nand_host_pkg::ST_IDLE:
        begin
          if (accept)
          begin
            kind_reg <= req_kind;
            data_reg <= req_data;
            col_reg  <= col_fix(req_col, bus_x16);
            page_reg <= req_page;
            blk_reg  <= req_block;
            x16_reg  <= bus_x16;
            idx_reg  <= 3'h0;
            if (req_kind == nand_host_pkg::KIND_WAIT)
            begin
              cnt_reg   <= nand_host_pkg::WB_CYC;
              state_reg <= nand_host_pkg::ST_WAIT_WB;
            end
            else if (req_kind <= nand_host_pkg::KIND_READ)
            begin
              state_reg <= nand_host_pkg::ST_SETUP;
            end
          end
        end
        nand_host_pkg::ST_SETUP:
        begin
          cnt_reg   <= (kind_reg == nand_host_pkg::KIND_READ) ?
                       nand_host_pkg::RD_LOW_CYC : nand_host_pkg::WE_LOW_CYC;
          state_reg <= nand_host_pkg::ST_STROBE;
        end
        nand_host_pkg::ST_STROBE:
        begin
          if (cnt_reg == 4'h1)
          begin
            cnt_reg   <= nand_host_pkg::WE_HIGH_CYC;
            state_reg <= nand_host_pkg::ST_HOLD;
          end
          else
          begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        nand_host_pkg::ST_HOLD:
        begin
          if (cnt_reg != 4'h1)
          begin
            cnt_reg <= cnt_reg - 4'h1;
          end
          else if ((kind_reg == nand_host_pkg::KIND_ADDR) &&
                   (idx_reg != nand_host_pkg::ADDR_LAST))
          begin
            idx_reg   <= idx_reg + 3'h1;
            state_reg <= nand_host_pkg::ST_SETUP;
          end
          else
          begin
            state_reg <= nand_host_pkg::ST_IDLE;
          end
        end
        nand_host_pkg::ST_WAIT_WB:
        begin
          // Busy may take a while to fall after the last strobe
          if (cnt_reg == 4'h1)
          begin
            state_reg <= nand_host_pkg::ST_WAIT_RDY;
          end
          else
          begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        nand_host_pkg::ST_WAIT_RDY:
        begin
          if (rb_s2)
          begin
            state_reg <= nand_host_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= nand_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pins are registered from the state, one cycle behind it, so they never glitch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ce_n          <= 1'b1;
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_n          <= 1'b1;
      read_strobe_n <= 1'b1;
      io_oe         <= 1'b0;
      io_out        <= 16'h0000;
    end
    else
    begin
      ce_n          <= !active;
      cle           <= active && (kind_reg == nand_host_pkg::KIND_CMD);
      ale           <= active && (kind_reg == nand_host_pkg::KIND_ADDR);
      we_n          <= !((state_reg == nand_host_pkg::ST_STROBE) &&
                         (kind_reg != nand_host_pkg::KIND_READ));
      read_strobe_n <= !((state_reg == nand_host_pkg::ST_STROBE) &&
                         (kind_reg == nand_host_pkg::KIND_READ));
      io_oe         <= active && (kind_reg != nand_host_pkg::KIND_READ);
      unique case (kind_reg)
        nand_host_pkg::KIND_CMD:   io_out <= {8'h00, data_reg[7:0]};
        nand_host_pkg::KIND_ADDR:
          io_out <= {8'h00, addr_cycle(idx_reg, col_reg, page_reg, blk_reg, x16_reg)};
        nand_host_pkg::KIND_WRITE:
          io_out <= x16_reg ? data_reg : {8'h00, data_reg[7:0]};
        default:                   io_out <= 16'h0000;
      endcase
    end
  end

  // Program guard and strap are steady levels, never pulsed in standby
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_n        <= 1'b0;
      block_guard <= 1'b0;
    end
    else
    begin
      wp_n        <= prog_enable;
      block_guard <= lock_enable;
    end
  end

  // Data and cache register roles are device-internal; the buffer absorbs stalls
  pair_buffer u_rd_buf
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (x16_reg ? io_s2 : {8'h00, io_s2[7:0]}),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  logic [2:0] we_rise_cnt;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      we_rise_cnt <= 3'h0;
    end
    else if (!ale)
    begin
      we_rise_cnt <= 3'h0;
    end
    else if ($rose(we_n))
    begin
      we_rise_cnt <= we_rise_cnt + 3'h1;
    end
  end

  sequence s_write_strobe;
    $fell(we_n) ##1 we_n;
  endsequence

  sequence s_read_strobe;
    !read_strobe_n [*4] ##1 read_strobe_n;
  endsequence

  property p_cle_ale_excl;
    @(posedge clk) disable iff (!arst_n) !(cle && ale);
  endproperty
  a_cle_ale_excl: assert property (p_cle_ale_excl) else $error("cle and ale both high");

  property p_we_ce;
    @(posedge clk) disable iff (!arst_n) !we_n |-> (!ce_n && read_strobe_n);
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe outside select");

  property p_re_ce;
    @(posedge clk) disable iff (!arst_n)
      !read_strobe_n |-> (!ce_n && we_n && !cle && !ale && !io_oe);
  endproperty
  a_re_ce: assert property (p_re_ce) else $error("read strobe with bad levels");

  property p_low_byte;
    @(posedge clk) disable iff (!arst_n) (io_oe && (cle || ale)) |-> (io_out[15:8] == 8'h00);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("upper byte set in cmd or addr");

  property p_five_addr;
    @(posedge clk) disable iff (!arst_n) $fell(ale) |-> (we_rise_cnt == 3'h5);
  endproperty
  a_five_addr: assert property (p_five_addr) else $error("address phase not five cycles");

  property p_we_pulse;
    @(posedge clk) disable iff (!arst_n) $fell(we_n) |-> s_write_strobe;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");

  property p_re_pulse;
    @(posedge clk) disable iff (!arst_n) $fell(read_strobe_n) |-> s_read_strobe;
  endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read strobe width wrong");

  property p_wp_follow;
    // The first edge after release still shows the reset level of the pin
    @(posedge clk) disable iff (!arst_n) $past(arst_n) |-> (wp_n == $past(prog_enable));
  endproperty
  a_wp_follow: assert property (p_wp_follow) else $error("program guard lags enable");

  property p_x8_col_hi;
    @(posedge clk) disable iff (!arst_n)
      (ale && !we_n && !x16_reg && (we_rise_cnt == 3'h1)) |-> (io_out[7:4] == 4'h0);
  endproperty
  a_x8_col_hi: assert property (p_x8_col_hi) else $error("second address cycle high nibble");

  property p_read_push;
    @(posedge clk) disable iff (!arst_n) push |=> rd_valid;
  endproperty
  a_read_push: assert property (p_read_push) else $error("read word not buffered");

endmodule : nand_host_port

// file: testbench/nand_device_model.sv
`timescale 1ns/1ps
module nand_device_model
(
  input  wire logic        clk,
  input  wire logic        pwr_ok,
  input  wire logic        dev_x16,
  input  wire logic [7:0]  busy_len,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        read_strobe_n,
  input  wire logic        wp_n,
  input  wire logic        block_guard,
  input  wire logic [15:0] io_out,
  input  wire logic        io_oe,
  output logic [15:0]      io_in,
  output logic             ready_busy_n
);
  localparam logic [7:0] PROG_GO = 8'h10;
  localparam logic [7:0] READ_GO = 8'h30;
  logic [7:0]  cmd_reg;
  logic [7:0]  addr_reg [5];
  logic [2:0]  addr_cnt;
  logic [7:0]  hi_seen;
  logic [15:0] cache [16];
  logic [3:0]  ptr;
  logic [15:0] dev_q;
  logic        dev_oe;
  logic        lock_on;
  logic        plane;
  logic [7:0]  prog_count;
  logic [7:0]  busy_cnt;
  logic        go;

  initial
  begin
    {cmd_reg, addr_cnt, hi_seen, ptr, dev_q, dev_oe} = '0;
    {lock_on, plane, prog_count, busy_cnt, go} = '0;
  end

  // Released bus shows the inverse of the last value, so a stale sample cannot pass
  assign io_in = io_oe ? io_out : (dev_oe ? dev_q : ~dev_q);
  // Open drain with the pull-up on the host side: high whenever not pulled low
  assign ready_busy_n = (busy_cnt == 8'h00);

  always @(posedge pwr_ok)
    lock_on = block_guard;

  always @(posedge we_n)
  begin
    if (!ce_n && read_strobe_n)
    begin
      if (cle && !ale)
      begin
        cmd_reg = io_out[7:0];
        addr_cnt = 3'h0;
        if (dev_x16)
          hi_seen = hi_seen | io_out[15:8];
        if (cmd_reg == PROG_GO || cmd_reg == READ_GO)
          go = 1'b1;
        if (cmd_reg == PROG_GO && wp_n)
          prog_count = prog_count + 8'h01;
      end
      else if (ale && !cle && addr_cnt < 3'h5)
      begin
        addr_reg[addr_cnt] = io_out[7:0];
        addr_cnt = addr_cnt + 3'h1;
        if (dev_x16)
          hi_seen = hi_seen | io_out[15:8];
        plane = addr_reg[2][6];
        ptr = 4'h0;
      end
      else if (!cle && !ale)
      begin
        cache[ptr] = dev_x16 ? io_out : {8'h00, io_out[7:0]};
        ptr = ptr + 4'h1;
      end
    end
  end

  always @(negedge read_strobe_n)
  begin
    if (!ce_n && !cle && !ale && we_n)
    begin
      dev_q = dev_x16 ? cache[ptr] : {~dev_q[15:8], cache[ptr][7:0]};
      dev_oe = 1'b1;
    end
  end

  always @(posedge read_strobe_n)
  begin
    if (dev_oe)
    begin
      dev_oe = 1'b0;
      ptr = ptr + 4'h1;
    end
  end

  always @(posedge clk)
  begin
    if (go)
    begin
      busy_cnt <= busy_len;
      go = 1'b0;
    end
    else if (busy_cnt != 8'h00)
      busy_cnt <= busy_cnt - 8'h01;
  end
endmodule : nand_device_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                     clk;
  logic                     arst_n;
  logic                     req_valid;
  logic                     req_ready;
  nand_host_pkg::req_kind_t req_kind;
  logic [15:0]              req_data;
  logic [11:0]              req_col;
  logic [5:0]               req_page;
  logic [10:0]              req_block;
  logic                     bus_x16;
  logic                     prog_enable;
  logic                     lock_enable;
  logic                     rd_valid;
  logic                     rd_ready;
  logic [15:0]              rd_data;
  logic                     busy;
  logic                     ce_n;
  logic                     cle;
  logic                     ale;
  logic                     we_n;
  logic                     read_strobe_n;
  logic                     wp_n;
  logic                     block_guard;
  logic [15:0]              io_out;
  logic                     io_oe;
  logic [15:0]              io_in;
  logic                     ready_busy_n;
  logic                     pwr_ok;
  logic [7:0]               busy_len;
  int                       fail_count;
  int                       n_compared;

  nand_host_port u_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_data(req_data), .req_col(req_col),
    .req_page(req_page), .req_block(req_block), .bus_x16(bus_x16),
    .prog_enable(prog_enable), .lock_enable(lock_enable), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .block_guard(block_guard),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));

  nand_device_model u_dev (.clk(clk), .pwr_ok(pwr_ok), .dev_x16(bus_x16),
    .busy_len(busy_len), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .block_guard(block_guard),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic send(input nand_host_pkg::req_kind_t k, input logic [15:0] d);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_data  <= d;
    @(negedge clk);
    for (n = 0; n < 200 && req_ready !== 1'b1; n++)
      @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    for (n = 0; n < 400 && busy !== 1'b0; n++)
      @(negedge clk);
  endtask : send

  task automatic addr(input logic [11:0] c, input logic [5:0] p, input logic [10:0] b);
    @(posedge clk);
    req_col   <= c;
    req_page  <= p;
    req_block <= b;
    send(nand_host_pkg::KIND_ADDR, 16'h0000);
  endtask : addr

  task automatic pop(input logic [15:0] exp, input logic [15:0] m);
    int n;
    @(negedge clk);
    for (n = 0; n < 50 && rd_valid !== 1'b1; n++)
      @(negedge clk);
    check("read valid", 16'h0001, {15'h0000, rd_valid});
    check("read data", exp & m, rd_data & m);
    // Take the word only after it has been judged, exactly one pop
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
  endtask : pop

  function automatic logic [7:0] exp_byte(input int i, input logic [11:0] c,
    input logic [5:0] p, input logic [10:0] b, input logic x);
    logic [11:0] k;
    k = c;
    if (x)
      k[11] = 1'b0;
    if (!x && c[11])
      k[10:6] = 5'h00;
    if (x && c[10])
      k[9:5] = 5'h00;
    case (i)
      0: return k[7:0];
      1: return x ? {5'h00, k[10:8]} : {4'h0, k[11:8]};
      2: return {b[1:0], p};
      3: return b[9:2];
      default: return {7'h00, b[10]};
    endcase
  endfunction : exp_byte

  task automatic s_address(input logic x, input logic [11:0] c, input logic [5:0] p,
    input logic [10:0] b);
    @(posedge clk);
    bus_x16 <= x;
    // Upper byte set on purpose: it must never reach the pins
    send(nand_host_pkg::KIND_CMD, 16'hff00);
    check("command", 16'h0000, {8'h00, u_dev.cmd_reg});
    addr(c, p, b);
    for (int i = 0; i < 5; i++)
      check("address byte", {8'h00, exp_byte(i, c, p, b, x)}, {8'h00, u_dev.addr_reg[i]});
    check("address count", 16'h0005, {13'h0000, u_dev.addr_cnt});
    check("plane", {15'h0000, b[0]}, {15'h0000, u_dev.plane});
    check("upper byte", 16'h0000, {8'h00, u_dev.hi_seen});
  endtask : s_address

  task automatic s_data(input logic x);
    logic [15:0] m;
    logic [7:0]  pc;
    m = x ? 16'hffff : 16'h00ff;
    @(posedge clk);
    bus_x16  <= x;
    busy_len <= 8'd40;
    rd_ready <= 1'b0;
    pc = u_dev.prog_count;
    send(nand_host_pkg::KIND_CMD, 16'h0080);
    addr(12'h000, 6'h01, 11'h002);
    for (int n = 0; n < 3; n++)
      send(nand_host_pkg::KIND_WRITE, 16'hc3a0 + 16'(n));
    send(nand_host_pkg::KIND_CMD, 16'h0010);
    send(nand_host_pkg::KIND_WAIT, 16'h0000);
    check("ready after wait", 16'h0001, {15'h0000, ready_busy_n});
    check("program count", {8'h00, pc + 8'h01}, {8'h00, u_dev.prog_count});
    send(nand_host_pkg::KIND_CMD, 16'h0000);
    addr(12'h000, 6'h01, 11'h002);
    send(nand_host_pkg::KIND_CMD, 16'h0030);
    send(nand_host_pkg::KIND_WAIT, 16'h0000);
    send(nand_host_pkg::KIND_READ, 16'h0000);
    send(nand_host_pkg::KIND_READ, 16'h0000);
    // Buffer now full with the receiver stalled: a third read must wait
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind  <= nand_host_pkg::KIND_READ;
    @(negedge clk);
    check("read refused", 16'h0000, {15'h0000, req_ready});
    @(posedge clk);
    req_valid <= 1'b0;
    pop(16'hc3a0, m);
    pop(16'hc3a1, m);
    send(nand_host_pkg::KIND_READ, 16'h0000);
    pop(16'hc3a2, m);
  endtask : s_data

  task automatic s_protect();
    logic [7:0] pc;
    @(posedge clk);
    prog_enable <= 1'b0;
    busy_len    <= 8'd2;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("program guard pin", 16'h0000, {15'h0000, wp_n});
    pc = u_dev.prog_count;
    send(nand_host_pkg::KIND_CMD, 16'h0080);
    addr(12'h010, 6'h3f, 11'h7ff);
    send(nand_host_pkg::KIND_WRITE, 16'h5a5a);
    send(nand_host_pkg::KIND_CMD, 16'h0010);
    send(nand_host_pkg::KIND_WAIT, 16'h0000);
    check("blocked program", {8'h00, pc}, {8'h00, u_dev.prog_count});
    check("chip select idle", 16'h0001, {15'h0000, ce_n});
  endtask : s_protect

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run is near 550 cycles; over thirty times that means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    {arst_n, req_valid, req_data, req_col, req_page, req_block, bus_x16} = '0;
    {pwr_ok, fail_count, n_compared} = '0;
    req_kind    = nand_host_pkg::KIND_CMD;
    prog_enable = 1'b1;
    lock_enable = 1'b1;
    rd_ready    = 1'b1;
    busy_len    = 8'd2;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("chip select", 16'h0001, {15'h0000, ce_n});
    check("strobes", 16'h0003, {14'h0000, we_n, read_strobe_n});
    check("latches", 16'h0000, {13'h0000, cle, ale, io_oe});
    check("guards", 16'h0000, {14'h0000, wp_n, block_guard});
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    pwr_ok <= 1'b1;
    @(negedge clk);
    check("lock strap", 16'h0001, {15'h0000, u_dev.lock_on});
    check("program guard pin", 16'h0001, {15'h0000, wp_n});
    s_address(1'b0, 12'h8ff, 6'h2a, 11'h5b3);
    s_address(1'b0, 12'h7c5, 6'h15, 11'h24c);
    s_address(1'b1, 12'hfff, 6'h3f, 11'h7ff);
    s_address(1'b1, 12'h3e1, 6'h00, 11'h401);
    s_data(1'b0);
    s_data(1'b1);
    s_protect();
    summarize();
  end
endmodule : testbench
